// ### fsp_ctrl.sv
// Flash self-programming controller with concurrent-read and halting regions
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_ctrl #(
   parameter int PROG_CYCLES = `FSP_PROG_TIME_NS / `FSP_CLK_PERIOD_NS
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [1:0]  BOOT_SIZE_FUSES,
   input  wire logic [14:0] FETCH_ADDR,
   output logic             FETCH_VALID,
   output logic             CORE_STALL,
   output logic             FLASH_ERASE,
   output logic             FLASH_WRITE,
   output logic [14:0]      FLASH_ADDR
);
   import fsp_pkg::*;

   // ------------------------------------------------------------------
   // Address region decode
   // ------------------------------------------------------------------
   logic [1:0]  fuse_s1_reg;
   logic [1:0]  fuse_s2_reg;
   logic [14:0] fetch_reg;

   // Boot region start from the fuse setting
   function automatic logic [14:0] boot_base(input logic [1:0] sz);
      case (sz)
         2'h3:    boot_base = `FSP_BOOT_512;
         2'h2:    boot_base = `FSP_BOOT_1K;
         2'h1:    boot_base = `FSP_BOOT_2K;
         default: boot_base = `FSP_BOOT_4K;
      endcase
   endfunction

   // Region tests, used for fetch and target addresses
   function automatic logic in_boot(input logic [14:0] a, input logic [1:0] sz);
      in_boot = (a >= boot_base(sz));
   endfunction

   function automatic logic in_halting(input logic [14:0] a);
      in_halting = (a >= `FSP_HALT_BASE);
   endfunction

   // Fuse pins come from outside: two flops; the fetch address below takes one
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         fuse_s1_reg <= 2'h0;
         fuse_s2_reg <= 2'h0;
      end else begin
         fuse_s1_reg <= BOOT_SIZE_FUSES;
         fuse_s2_reg <= fuse_s1_reg;
      end
   end

   // Fetch address sampled so the issuing region is known
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         fetch_reg <= 15'h0000;
      end else begin
         fetch_reg <= FETCH_ADDR;
      end
   end

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   fsp_job_t    job_reg;
   fsp_job_t    job_next;
   logic [14:0] addr_reg;
   logic [14:0] addr_next;
   logic [3:0]  lock_reg;
   logic [3:0]  lock_next;
   logic        busy_reg;
   logic        busy_next;
   logic        refused_reg;
   logic        refused_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        start;
   logic        done;
   logic        wr_acc;
   logic        rd_acc;
   logic        tgt_boot;
   logic        allowed;
   fsp_op_t     req_op;

   // Writes land at the access edge; reads are decoded in the setup cycle
   // so the registered read data already stands while ready is high
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && !PENABLE && !PWRITE;

   // Requested operation from a control write
   always_comb begin
      req_op = FSP_OP_NONE;
      if (wr_acc && (PADDR == `FSP_OFF_CTRL)) begin
         if (PWDATA[`FSP_CTRL_ERASE]) begin
            req_op = FSP_OP_ERASE;
         end else if (PWDATA[`FSP_CTRL_WRITE]) begin
            req_op = FSP_OP_WRITE;
         end
      end
   end

   // Permission check on issuing region and target locks
   always_comb begin
      tgt_boot = in_boot(addr_reg, fuse_s2_reg);
      // Either lock bit of a pair low (3:2 boot, 1:0 other) forbids writing the matching region
      if (tgt_boot) begin
         allowed = lock_reg[3] && lock_reg[2];
      end else begin
         allowed = lock_reg[1] && lock_reg[0];
      end
      allowed = allowed && in_boot(fetch_reg, fuse_s2_reg);
      start   = (req_op != FSP_OP_NONE) && !job_reg.active && allowed;
   end

   // Next values for job, registers and read data
   always_comb begin
      job_next     = job_reg;
      addr_next    = addr_reg;
      lock_next    = lock_reg;
      busy_next    = busy_reg;
      refused_next = refused_reg;
      rdata_next   = rdata_reg;
      if (wr_acc && (PADDR == `FSP_OFF_ADDR)) begin
         addr_next = PWDATA[14:0];
      end
      if (wr_acc && (PADDR == `FSP_OFF_LOCK)) begin
         lock_next = lock_reg & PWDATA[3:0]; // Locks can only be programmed
      end
      if (wr_acc && (PADDR == `FSP_OFF_CTRL) && PWDATA[`FSP_CTRL_CLR_BUSY]
          && !job_reg.active) begin
         busy_next = 1'b0;
         refused_next = 1'b0;
      end
      // A refusal in the same write as the clear still sets the flag
      if ((req_op != FSP_OP_NONE) && !start) begin
         refused_next = 1'b1;
      end
      if (done) begin
         job_next.active = 1'b0;
      end
      if (start) begin
         job_next.active  = 1'b1;
         job_next.op      = req_op;
         job_next.addr    = addr_reg;
         job_next.halting = in_halting(addr_reg);
         if (!in_halting(addr_reg)) begin
            busy_next = 1'b1;
         end
      end
      if (rd_acc) begin
         case (PADDR)
            `FSP_OFF_ADDR:   rdata_next = {17'h00000, addr_reg};
            `FSP_OFF_LOCK:   rdata_next = {28'h0000000, lock_reg};
            `FSP_OFF_STATUS: begin
               rdata_next = 32'h0000_0000;
               rdata_next[`FSP_ST_BUSY_FLAG] = busy_reg;
               rdata_next[`FSP_ST_ACTIVE]    = job_reg.active;
               rdata_next[`FSP_ST_STALL]     = CORE_STALL;
               rdata_next[`FSP_ST_REFUSED]   = refused_reg;
            end
            default:         rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         job_reg     <= '{active: 1'b0, halting: 1'b0, op: FSP_OP_NONE, addr: 15'h0000};
         addr_reg    <= 15'h0000;
         lock_reg    <= `FSP_LOCK_RESET;
         busy_reg    <= 1'b0;
         refused_reg <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         job_reg     <= job_next;
         addr_reg    <= addr_next;
         lock_reg    <= lock_next;
         busy_reg    <= busy_next;
         refused_reg <= refused_next;
         rdata_reg   <= rdata_next;
      end
   end

   // ------------------------------------------------------------------
   // Programming timer
   // ------------------------------------------------------------------
   fsp_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .start (start),
      .done  (done)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Stall holds the core in place; release resumes the next fetch
   assign CORE_STALL  = job_reg.active && job_reg.halting;
   // Halting-region fetch stays valid unless the core is stalled; concurrent-region fetch is blocked while busy is set
   assign FETCH_VALID = !CORE_STALL && !(busy_reg && !in_halting(fetch_reg));
   assign FLASH_ERASE = job_reg.active && (job_reg.op == FSP_OP_ERASE);
   assign FLASH_WRITE = job_reg.active && (job_reg.op == FSP_OP_WRITE);
   assign FLASH_ADDR  = job_reg.addr;
   assign PRDATA      = rdata_reg;
   assign PREADY      = PSEL && PENABLE;
   assign PSLVERR     = PSEL && PENABLE && (PADDR[1:0] != 2'h0 || PADDR > `FSP_OFF_LOCK);
endmodule

// ### fsp_cfg.svh
// Constants for the flash self-programming controller
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ----------------------------------------------------------------------
// Register map (word aligned byte offsets)
// ----------------------------------------------------------------------
`define FSP_OFF_CTRL       12'h000
`define FSP_OFF_ADDR       12'h004
`define FSP_OFF_STATUS     12'h008
`define FSP_OFF_LOCK       12'h00C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FSP_CTRL_ERASE     0
`define FSP_CTRL_WRITE     1
`define FSP_CTRL_CLR_BUSY  2

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define FSP_ST_BUSY_FLAG   0
`define FSP_ST_ACTIVE      1
`define FSP_ST_STALL       2
`define FSP_ST_REFUSED     3

// ----------------------------------------------------------------------
// Flash geometry and timing
// ----------------------------------------------------------------------
`define FSP_ADDR_W         15
`define FSP_HALT_BASE      15'h7000
`define FSP_BOOT_512       15'h7E00
`define FSP_BOOT_1K        15'h7C00
`define FSP_BOOT_2K        15'h7800
`define FSP_BOOT_4K        15'h7000
`define FSP_PROG_TIME_NS   4000000
`define FSP_CLK_PERIOD_NS  5
`define FSP_LOCK_RESET     4'hF

`endif

// ### fsp_pkg.sv
// Types for the flash self-programming controller
package fsp_pkg;

   typedef enum logic [1:0] {
      FSP_OP_NONE  = 2'b00,
      FSP_OP_ERASE = 2'b01,
      FSP_OP_WRITE = 2'b10
   } fsp_op_t;

   typedef struct packed {
      logic        active;
      logic        halting;
      fsp_op_t     op;
      logic [14:0] addr;
   } fsp_job_t;

endpackage

// ### fsp_timer.sv
// Programming duration counter for the flash self-programming controller
`timescale 1ns/1ps
module fsp_timer #(
   parameter int CYCLES = 800000
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic start,
   output logic      done
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        done_next;
   logic        done_reg;

   // Count down from start, pulse done on expiry
   always_comb begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (start) begin
         cnt_next = 32'(CYCLES);
      end else if (cnt_reg != 32'h0000_0000) begin
         cnt_next = cnt_reg - 32'h0000_0001;
         if (cnt_reg == 32'h0000_0001) begin
            done_next = 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg  <= 32'h0000_0000;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule

// ### fsp_ctrl_properties.sv
// Concurrent checks on the self-programming controller ports
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_ctrl_properties #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic        CLK_SYS,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic        PREADY,
   input wire logic [14:0] FETCH_ADDR,
   input wire logic        FETCH_VALID,
   input wire logic        CORE_STALL,
   input wire logic        FLASH_ERASE,
   input wire logic        FLASH_WRITE,
   input wire logic [14:0] FLASH_ADDR
);
   logic        job;
   logic        conc;
   logic        ctrl_wr;
   logic [31:0] run_reg;
   logic [31:0] run_next;
   // Job decode and control-write strobe
   assign job     = FLASH_ERASE | FLASH_WRITE;
   assign conc    = FLASH_ADDR < `FSP_HALT_BASE;
   assign ctrl_wr = PSEL & PENABLE & PWRITE & (PADDR == `FSP_OFF_CTRL);
   // Cycles the current job has stood
   always_comb begin
      run_next = job ? run_reg + 32'h1 : 32'h0;
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         run_reg <= 32'h0;
      end else begin
         run_reg <= run_next;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access without ready");
   boot_start_a: assert property ($rose(job) |-> $past(FETCH_ADDR) >= `FSP_HALT_BASE)
      else $error("job started outside boot code");
   ctrl_start_a: assert property ($rose(job) |-> $past(ctrl_wr))
      else $error("job started without control write");
   halt_stall_a: assert property (job && !conc |-> CORE_STALL)
      else $error("halting target without stall");
   conc_run_a: assert property (job && conc |-> !CORE_STALL)
      else $error("concurrent target stalled core");
   conc_fetch_a: assert property (job && conc && FETCH_ADDR < `FSP_HALT_BASE
      && $stable(FETCH_ADDR) |-> !FETCH_VALID)
      else $error("concurrent fetch valid during job");
   halt_fetch_a: assert property (job && conc && FETCH_ADDR >= `FSP_HALT_BASE
      && $stable(FETCH_ADDR) |-> FETCH_VALID)
      else $error("halting fetch blocked during job");
   addr_hold_a: assert property (job && $past(job) |-> $stable(FLASH_ADDR))
      else $error("target address moved during job");
   job_length_a: assert property ($fell(job) |-> run_reg == PROG_CYCLES + 1)
      else $error("job length wrong");
   stall_end_a: assert property ($fell(CORE_STALL) |-> !job)
      else $error("stall released during job");
endmodule

bind fsp_ctrl fsp_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PREADY(PREADY), .FETCH_ADDR(FETCH_ADDR), .FETCH_VALID(FETCH_VALID),
   .CORE_STALL(CORE_STALL), .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE),
   .FLASH_ADDR(FLASH_ADDR));

// ### fsp_core_model.sv
// Behavioural core model supplying the executing instruction address
`timescale 1ns/1ps
module fsp_core_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        stall,
   input  wire logic        jump,
   input  wire logic [14:0] target,
   output logic [14:0]      pc
);
   logic [14:0] pc_reg;
   logic [14:0] pc_next;
   // Frozen while stalled, so execution resumes where it stopped
   always_comb begin
      pc_next = pc_reg;
      if (jump && !stall) begin
         pc_next = target;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_reg <= 15'h0000;
      end else begin
         pc_reg <= pc_next;
      end
   end
   assign pc = pc_reg;
endmodule

// ### tb_top.sv
// Self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`include "fsp_cfg.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   import fsp_pkg::*;
   localparam int PROG = 20;
   logic        CLK_SYS, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, jump, err_s;
   logic        FETCH_VALID, CORE_STALL, FLASH_ERASE, FLASH_WRITE;
   logic [1:0]  fuses;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [14:0] fetch, target, FLASH_ADDR;
   logic [14:0] bases [4] = '{`FSP_BOOT_4K, `FSP_BOOT_2K, `FSP_BOOT_1K, `FSP_BOOT_512};
   int          error_cnt, samples_checked, cycles;
   fsp_ctrl #(.PROG_CYCLES(PROG)) DUT (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .BOOT_SIZE_FUSES(fuses), .FETCH_ADDR(fetch),
      .FETCH_VALID(FETCH_VALID), .CORE_STALL(CORE_STALL), .FLASH_ERASE(FLASH_ERASE),
      .FLASH_WRITE(FLASH_WRITE), .FLASH_ADDR(FLASH_ADDR));
   fsp_core_model core (.clk(CLK_SYS), .rst_b(RST_B), .stall(CORE_STALL), .jump(jump),
      .target(target), .pc(fetch));
   // Clock and hang guard
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // APB transfer; data and error taken at the ready edge, then outputs settle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1);
      err_s = PSLVERR;
      rd = PRDATA;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      @(negedge CLK_SYS);
   endtask
   task automatic go(input logic [14:0] pc);
      @(posedge CLK_SYS);
      jump <= 1'b1; target <= pc;
      @(posedge CLK_SYS);
      jump <= 1'b0;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while ((FLASH_ERASE | FLASH_WRITE) !== 1'b0 && n < 200) begin
         @(posedge CLK_SYS);
         #1 n++;
      end
      `CHK("job end", 1'b0, FLASH_ERASE | FLASH_WRITE)
   endtask
   task automatic launch(input logic [14:0] a, input logic [31:0] op, input logic ex);
      apb(1'b1, `FSP_OFF_ADDR, {17'h0, a});
      apb(1'b1, `FSP_OFF_CTRL, op);
      `CHK("job", ex, FLASH_ERASE | FLASH_WRITE)
      if (ex) `CHK("target", a, FLASH_ADDR)
      wait_idle();
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_fuses();
      for (int i = 0; i < 4; i++) begin
         fuses <= i[1:0];
         repeat (4) @(posedge CLK_SYS);
         go(bases[i] - 15'h1);
         launch(15'h7F00, 32'h1, 1'b0);
         go(bases[i]);
         launch(15'h7F00, 32'h2, 1'b1);
      end
   endtask
   task automatic t_halt();
      apb(1'b1, `FSP_OFF_ADDR, 32'h7F10);
      apb(1'b1, `FSP_OFF_CTRL, 32'h1);
      `CHK("stall", 1'b1, CORE_STALL)
      apb(1'b1, `FSP_OFF_ADDR, 32'h0123);
      `CHK("held addr", 15'h7F10, FLASH_ADDR)
      wait_idle();
      `CHK("stall end", 1'b0, CORE_STALL)
      `CHK("resume pc", 15'h7E00, fetch)
   endtask
   task automatic t_conc();
      apb(1'b1, `FSP_OFF_ADDR, 32'h0200);
      apb(1'b1, `FSP_OFF_CTRL, 32'h2);
      `CHK("no stall", 1'b0, CORE_STALL)
      `CHK("halt fetch", 1'b1, FETCH_VALID)
      go(15'h0100);
      `CHK("conc fetch", 1'b0, FETCH_VALID)
      go(15'h7E00);
      apb(1'b0, `FSP_OFF_STATUS, 32'h0);
      `CHK("busy run", 1'b1, rd[0])
      wait_idle();
      apb(1'b0, `FSP_OFF_STATUS, 32'h0);
      `CHK("busy kept", 1'b1, rd[0])
      apb(1'b1, `FSP_OFF_CTRL, 32'h4);
      apb(1'b0, `FSP_OFF_STATUS, 32'h0);
      `CHK("busy clr", 1'b0, rd[0])
   endtask
   task automatic t_lock();
      apb(1'b0, `FSP_OFF_LOCK, 32'h0);
      `CHK("lock rst", `FSP_LOCK_RESET, rd[3:0])
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped", 1'b1, err_s)
      apb(1'b1, `FSP_OFF_LOCK, 32'hC);
      launch(15'h0200, 32'h1, 1'b0);
      launch(15'h7F00, 32'h1, 1'b1);
      apb(1'b1, `FSP_OFF_LOCK, 32'h3);
      launch(15'h7F00, 32'h1, 1'b0);
      apb(1'b0, `FSP_OFF_STATUS, 32'h0);
      `CHK("refused", 1'b1, rd[3])
   endtask
   // Main sequence
   initial begin
      RST_B = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000;
      PWDATA = 32'h0; fuses = 2'h3; jump = 1'b0; target = 15'h0000;
      error_cnt = 0; samples_checked = 0; cycles = 0;
      repeat (3) @(posedge CLK_SYS);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      t_fuses();
      t_halt();
      t_conc();
      t_lock();
      give_verdict();
   end
endmodule
